/* tb_top_speed_limit_command_check.sv */
// Bench: sender and receiver joined by one link, plus a second receiver
// whose link the bench drives with good, ignored and faulty frames. Assumes one 250 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module tb_top_speed_limit_command_check
   import tsl_pkg::*;
;
   localparam int PER = 16;
   logic        ref_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [2:0]  hsel = 3'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        other_lim = 1'b0;
   logic [2:0]  rdy;
   logic [31:0] rdv [3];
   logic [2:0]  dsel_q = 3'h0;
   logic        rd_ph_q = 1'b0;
   logic        hready;
   logic [31:0] hrdata;
   logic        act_a;
   logic        act_b;
   logic [7:0]  val_a;
   logic [7:0]  val_b;
   logic        flt_b;
   logic        flt_a;
   logic [2:0]  resp;
   logic [2:0]  irq;
   logic [31:0] seed = 32'hF0DE5EFD;
   logic [31:0] ident_a;
   logic [31:0] ident_b;
   logic [7:0]  v;
   logic [31:0] exp_q [$];
   int          n_errors = 0;
   int          checks_done = 0;

   tsl_if link_a ();
   tsl_if link_b ();

   // Clock and bus glue; every slave answers, data comes from the selected one
   always #2 ref_clk_i = ~ref_clk_i;
   assign hready = &rdy;
   assign hrdata = dsel_q[0] ? rdv[0] : (dsel_q[1] ? rdv[1] : rdv[2]);

   tsl_sender #(.PERIOD_CYC(PER)) u_tsl_sender (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .hsel_i(hsel[0]), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(rdv[0]), .hreadyout_o(rdy[0]),
      .hresp_o(resp[0]), .irq_o(irq[0]), .link(link_a));
   tsl_receiver u_tsl_receiver (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .hsel_i(hsel[1]), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(rdv[1]), .hreadyout_o(rdy[1]),
      .hresp_o(resp[1]), .other_limit_i(1'b0), .limit_active_o(act_a), .limit_value_o(val_a),
      .diagnostic_fault_code_o(flt_a), .irq_o(irq[1]), .link(link_a));
   tsl_receiver u_tsl_receiver_b (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .hsel_i(hsel[2]), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(rdv[2]), .hreadyout_o(rdy[2]),
      .hresp_o(resp[2]), .other_limit_i(other_lim), .limit_active_o(act_b), .limit_value_o(val_b),
      .diagnostic_fault_code_o(flt_b), .irq_o(irq[2]), .link(link_b));
   tsl_link_monitor u_tsl_link_monitor (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .frame(link_a.frame), .req(link_a.req), .roll(link_a.roll),
      .password(link_a.password), .value(link_a.value), .reduced_power(link_a.reduced_power));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected password: per byte negated character plus count, carry dropped
   function automatic logic [31:0] pw(input logic [31:0] c, input logic [1:0] r);
      for (int i = 0; i < 4; i++) pw[8*i+:8] = 8'h00 - c[8*i+:8] + {6'h0, r};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // One single transfer; the master waits on hready, never on a count
   task automatic ahb(input logic [2:0] s, input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= s;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk_i); while (hready !== 1'b1);
   endtask

   task automatic wr(input logic [2:0] s, input logic [7:0] a, input logic [31:0] d);
      ahb(s, 1'b1, a, d);
   endtask

   task automatic rd(input logic [2:0] s, input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      ahb(s, 1'b0, a, 32'h0);
   endtask

   // Bench frame on the second link; password and value turn over once sampled
   task automatic send(input req_code_e q, input logic [1:0] r, input logic [31:0] p,
                       input logic [7:0] val);
      link_b.frame <= 1'b1;
      link_b.req <= q;
      link_b.roll <= r;
      link_b.password <= p;
      link_b.value <= val;
      @(posedge ref_clk_i);
      link_b.frame <= 1'b0;
      link_b.password <= ~p;
      link_b.value <= ~val;
      @(posedge ref_clk_i);
   endtask

   task automatic st_b(input logic a, input logic [7:0] val, input logic f);
      chk({22'h0, flt_b, act_b, val_b}, {22'h0, f, a, val});
   endtask

   // Read checker: oldest note against the data phase that just ended
   always @(posedge ref_clk_i) begin
      if (rd_ph_q && hready === 1'b1) chk(hrdata, exp_q.pop_front());
      if (hready === 1'b1) rd_ph_q <= htrans[1] && !hwrite;
      if (hready === 1'b1 && htrans[1]) dsel_q <= hsel;
   end

   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_errors++;
      report_and_stop();
   end

   initial begin
      link_b.frame = 1'b0;
      link_b.req = REQ_NO_ACTION;
      link_b.roll = 2'h0;
      link_b.password = 32'h0;
      link_b.value = 8'hFF;
      repeat (16) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge ref_clk_i);
      // Reset values, an unmapped place, identity and masks
      rd(3'h2, 8'h04, 32'h8);
      rd(3'h2, 8'h08, 32'h0000FF00);
      rd(3'h1, 8'h04, 32'hFF);
      rd(3'h1, 8'h08, 32'h1);
      rd(3'h2, 8'h14, 32'h0);
      ident_a = xs();
      ident_b = 32'h01020300; // Top byte overflows once the count is added
      wr(3'h1, 8'h00, ident_a);
      wr(3'h2, 8'h00, ident_a);
      rd(3'h2, 8'h00, ident_a);
      wr(3'h2, 8'h10, 32'hF);
      wr(3'h1, 8'h10, 32'h1);
      wr(3'h4, 8'h00, ident_b);
      wr(3'h4, 8'h04, 32'h2);
      // Limit order through the real sender
      v = 8'(xs());
      if (v == 8'hFF) v = 8'hFE;
      wr(3'h1, 8'h04, {23'h0, 1'b1, v});
      for (int i = 0; i < 3 * PER && act_a !== 1'b1; i++) @(posedge ref_clk_i);
      chk(32'({act_a, val_a}), 32'({1'b1, v}));
      rd(3'h2, 8'h08, {16'h0, v, 8'h03});
      rd(3'h1, 8'h08, 32'h12);
      chk(32'(irq[1]), 32'h1);
      rd(3'h2, 8'h0C, 32'h1);
      // Reset order, repeated until the indication drops
      wr(3'h1, 8'h04, 32'h1FF);
      for (int i = 0; i < 6 * PER && irq[0] !== 1'b1; i++) @(posedge ref_clk_i);
      chk(32'({link_a.reduced_power, act_a, val_a}), 32'h0FF);
      rd(3'h1, 8'h08, 32'h8);
      rd(3'h1, 8'h0C, 32'h3);
      repeat (2 * PER) @(posedge ref_clk_i);
      // Second receiver: accepted, ignored and faulty frames
      send(REQ_ACTIVE, 2'h1, pw(ident_b, 2'h1), 8'h20);
      st_b(1'b1, 8'h20, 1'b0);
      send(REQ_NO_ACTION, 2'h3, 32'h0, 8'h05);
      st_b(1'b1, 8'h20, 1'b0);
      send(req_code_e'(2'h3), 2'h2, 32'h0, 8'h06);
      st_b(1'b1, 8'h20, 1'b0);
      send(REQ_ACTIVE, 2'h2, pw(ident_b, 2'h2) ^ 32'h1, 8'h10);
      st_b(1'b1, 8'h20, 1'b0);
      rd(3'h4, 8'h08, 32'h00002013);
      other_lim <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      send(REQ_ACTIVE, 2'h3, pw(ident_b, 2'h3), 8'hFF);
      st_b(1'b0, 8'hFF, 1'b0);
      chk(32'(link_b.reduced_power), 32'h1);
      other_lim <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      chk(32'(link_b.reduced_power), 32'h0);
      send(REQ_ACTIVE, 2'h0, pw(ident_b, 2'h0), 8'h30);
      st_b(1'b1, 8'h30, 1'b0);
      send(REQ_INACTIVE, 2'h1, 32'h0, 8'hFF);
      st_b(1'b0, 8'hFF, 1'b0);
      send(REQ_ACTIVE, 2'h3, pw(ident_b, 2'h3), 8'h40);
      st_b(1'b0, 8'hFF, 1'b0);
      chk(32'(irq[2]), 32'h0);
      send(REQ_ACTIVE, 2'h0, pw(ident_b, 2'h0) ^ 32'h80000000, 8'h40);
      st_b(1'b0, 8'hFF, 1'b1);
      send(REQ_ACTIVE, 2'h1, pw(ident_b, 2'h1), 8'h40);
      st_b(1'b0, 8'hFF, 1'b1);
      // Interrupt: unmask, read to clear, then quiet
      wr(3'h4, 8'h10, 32'h8);
      repeat (2) @(posedge ref_clk_i);
      chk(32'(irq[2]), 32'h1);
      rd(3'h4, 8'h0C, 32'hF);
      repeat (2) @(posedge ref_clk_i);
      chk(32'(irq[2]), 32'h0);
      rd(3'h4, 8'h0C, 32'h0);
      // Clean link never faults; every slave answers OKAY
      chk(32'({flt_a, resp}), 32'h0);
      // Let the read checker take the last data phase first
      @(posedge ref_clk_i);
      if (exp_q.size() != 0) n_errors++;
      report_and_stop();
   end
endmodule // tb_top_speed_limit_command_check

`default_nettype wire

/* tsl_if.sv */
// Command link between the telematics sender and the engine receiver.
// Assumes both ends share ref_clk_i; a frame is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none

interface tsl_if;
   import tsl_pkg::*;

   logic        frame;          // One-cycle pulse, fields valid
   req_code_e   req;
   logic [1:0]  roll;
   logic [31:0] password;
   logic [7:0]  value;          // Speed limit, km/h divided by two
   logic        reduced_power;  // Receiver indication back to sender

   modport dev (input frame, req, roll, password, value, output reduced_power);
   modport snd (output frame, req, roll, password, value, input reduced_power);
endinterface

`default_nettype wire

/* tsl_link_monitor.sv */
// Checker for the command link between the speed limit sender and receiver.
// Assumes a sender period of at least 9 cycles and a receiver whose
// other-cause limiting input is held low, so only frames move the indication.
`timescale 1ns/100ps
`default_nettype none

module tsl_link_monitor
   import tsl_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        sys_rst_i,
   input wire logic        frame,
   input wire req_code_e   req,
   input wire logic [1:0]  roll,
   input wire logic [31:0] password,
   input wire logic [7:0]  value,
   input wire logic        reduced_power
);
   logic        act;
   logic        have_q;
   logic [31:0] base;
   logic [31:0] base_q;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   // Password less the count, byte by byte; a borrow must not cross bytes
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         base[8*i+:8] = password[8*i+:8] - {6'h0, roll};
      end
   end
   assign act = frame && (req == REQ_ACTIVE);

   // Identity part of the last Active password
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         have_q <= 1'b0;
         base_q <= 32'h0;
      end else if (act) begin
         have_q <= 1'b1;
         base_q <= base;
      end
   end

   a_pw_only_active: assert property (
      frame && req != REQ_ACTIVE |-> password == 32'h0) else $error("password outside Active");
   a_pw_bytes_roll: assert property (
      act && have_q |-> base == base_q) else $error("password bytes inconsistent");
   a_inact_value_ff: assert property (
      frame && req == REQ_INACTIVE |-> value == 8'hFF) else $error("inactive value not FF");
   a_limit_sets_rp: assert property (
      act && value != 8'hFF |=> reduced_power) else $error("limit without indication");
   a_reset_clears_rp: assert property (
      act && value == 8'hFF |=> !reduced_power) else $error("reset left indication");
   a_inactive_normal: assert property (
      frame && req == REQ_INACTIVE |=> !reduced_power) else $error("inactive left limit");
   a_no_action_holds: assert property (
      frame && req == REQ_NO_ACTION |=> $stable(reduced_power)) else $error("no action moved");
   a_rp_on_frame: assert property (
      $changed(reduced_power) |-> $past(frame)) else $error("indication moved without frame");
   // Frames are single pulses spaced apart
   a_frame_gap: assert property (
      frame |=> !frame [*8]) else $error("frames too close");

   // Main traffic kinds seen on the link
   c_limit: cover property (act && value != 8'hFF);
   c_reset: cover property (act && value == 8'hFF ##1 !reduced_power);
   c_inactive: cover property (frame && req == REQ_INACTIVE);
endmodule // tsl_link_monitor

`default_nettype wire

/* tsl_password.sv */
// Password generator: four identity characters and a rolling count.
// Assumes chars_i[31:24] is character 14 and chars_i[7:0] character 17.
`timescale 1ns/100ps
`default_nettype none

module tsl_password (
   input  wire logic [31:0] chars_i,
   input  wire logic [1:0]  roll_i,
   output logic      [31:0] password_o
);

   function automatic logic [7:0] pw_byte(input logic [7:0] c, input logic [1:0] r);
      pw_byte = 8'((~c) + 8'h01 + {6'h00, r});
   endfunction

   // byte 4 from char 14 down to byte 1
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         password_o[i*8 +: 8] = pw_byte(chars_i[i*8 +: 8], roll_i);
      end
   end

endmodule // tsl_password

`default_nettype wire

/* tsl_pkg.sv */
// Types shared by both ends of the speed limit command link.
// Assumes tsl_regs.svh holds the numeric constants.
`default_nettype none

package tsl_pkg;

   // Request field codes of a command frame
   typedef enum logic [1:0] {
      REQ_NO_ACTION = 2'h0,
      REQ_ACTIVE    = 2'h1,
      REQ_INACTIVE  = 2'h2
   } req_code_e;

   // Receiver limiting state
   typedef enum logic [1:0] {
      ST_NORMAL = 2'b01,
      ST_LIMIT  = 2'b10
   } lim_state_e;

   // Sender order state
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001,
      S_LIMIT = 4'b0010,
      S_RESET = 4'b0100,
      S_INACT = 4'b1000
   } snd_state_e;

endpackage

`default_nettype wire

/* tsl_receiver.sv */
// Engine side: checks speed limit commands and drives the limit state.
// Assumes an AHB-Lite master on ref_clk_i and the sender on the link;
// other_limit_i is asynchronous and is synchronised here.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

`include "tsl_regs.svh"

// Function
// - Bad password: drop command, keep data
// - Repeated errors: set fault, reject later requests
// - Sender gives password only when Active
// - Password bytes from characters 14 to 17
// - Password byte keeps low eight bits
// - Act only on Active, good count, password
// - Value 510 resets limiting and indication
// - Value below 510 limits, feeds arbitration
// - Indication high while top speed limited
// - Sender repeats reset until indication false
// - Sender repeats limit until reset ordered
// - No Action ignored; Inactive resets limiting
// - Rolling count error: drop, keep data
module tsl_receiver
   import tsl_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        other_limit_i,
   output logic             limit_active_o,
   output logic      [7:0]  limit_value_o,
   output logic             diagnostic_fault_code_o,
   output logic             irq_o,
   tsl_if.dev               link
);

   // Bus side state
   logic        a_wr_q, a_wr_d;
   logic [7:0]  a_addr_q, a_addr_d;
   logic [31:0] ident_q, ident_d;
   logic [3:0]  thr_q, thr_d;
   logic [3:0]  mask_q, mask_d;
   logic [3:0]  irq_q, irq_d;
   logic [3:0]  irq_clr;
   logic [31:0] rdata_q, rdata_d;
   logic        irq_out_q, irq_out_d;
   logic        acc;

   // Link side state
   lim_state_e  st_q, st_d;
   logic [7:0]  val_q, val_d;
   logic [1:0]  prev_q, prev_d;
   logic        seen_q, seen_d;
   logic [3:0]  errs_q, errs_d;
   logic        fault_q, fault_d;
   logic        rp_q, rp_d;
   logic [3:0]  ev;
   logic        roll_ok, pw_ok;
   logic [31:0] exp_pw;
   logic        oth_s1_q, oth_s2_q;

   // Expected password for the count carried by this frame
   tsl_password u_pw (
      .chars_i    (ident_q),
      .roll_i     (link.roll),
      .password_o (exp_pw)
   );

   // Register writes, reads and read-to-clear status
   always_comb begin
      acc      = hsel_i && htrans_i[1] && hready_i;
      a_wr_d   = acc && hwrite_i;
      a_addr_d = acc ? haddr_i[7:0] : a_addr_q;
      ident_d  = ident_q;
      thr_d    = thr_q;
      mask_d   = mask_q;
      irq_clr  = 4'h0;
      rdata_d  = 32'h00000000;
      if (a_wr_q) begin
         case (a_addr_q)
            `TSL_OFS_IDENT:    ident_d = hwdata_i;
            `TSL_OFS_CTRL:     thr_d  = hwdata_i[3:0];
            `TSL_OFS_IRQ_MASK: mask_d = hwdata_i[3:0];
            default: ;
         endcase
      end
      // Reads see a write still in its data phase
      if (acc && !hwrite_i) begin
         case (haddr_i[7:0])
            `TSL_OFS_IDENT:    rdata_d = ident_d;
            `TSL_OFS_CTRL:     rdata_d = {28'h0000000, thr_d};
            `TSL_OFS_STATUS:   rdata_d = {16'h0000, val_q, errs_q, 1'b0,
                                          fault_q, rp_q, st_q[1]};
            `TSL_OFS_IRQ_STAT: begin
               rdata_d = {28'h0000000, irq_q};
               irq_clr = irq_q;
            end
            `TSL_OFS_IRQ_MASK: rdata_d = {28'h0000000, mask_d};
            default:           rdata_d = 32'h00000000;
         endcase
      end
      // Set wins over a clear in the same cycle
      irq_d     = (irq_q & ~irq_clr) | ev;
      irq_out_d = |(irq_d & mask_d);
   end

   // Bus side registers
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         a_wr_q    <= 1'b0;
         a_addr_q  <= 8'h00;
         ident_q   <= `TSL_IDENT_RST;
         thr_q     <= `TSL_ERR_LIMIT_RST;
         mask_q    <= `TSL_MASK_RST;
         irq_q     <= 4'h0;
         rdata_q   <= 32'h00000000;
         irq_out_q <= 1'b0;
      end else begin
         a_wr_q    <= a_wr_d;
         a_addr_q  <= a_addr_d;
         ident_q   <= ident_d;
         thr_q     <= thr_d;
         mask_q    <= mask_d;
         irq_q     <= irq_d;
         rdata_q   <= rdata_d;
         irq_out_q <= irq_out_d;
      end
   end

   // Other-cause limiting comes from outside this clock
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         oth_s1_q <= 1'b0;
         oth_s2_q <= 1'b0;
      end else begin
         oth_s1_q <= other_limit_i;
         oth_s2_q <= oth_s1_q;
      end
   end

   // Command checking and limiting state
   always_comb begin
      st_d    = st_q;
      val_d   = val_q;
      prev_d  = prev_q;
      seen_d  = seen_q;
      errs_d  = errs_q;
      fault_d = fault_q;
      ev      = 4'h0;
      // count must follow the last one
      roll_ok = !seen_q || (link.roll == 2'(prev_q + 2'h1));
      pw_ok   = (link.password == exp_pw);
      // locked out once the fault is set
      if (link.frame && !fault_q) begin
         case (link.req)
            REQ_ACTIVE: begin
               prev_d = link.roll;
               seen_d = 1'b1;
               if (roll_ok && pw_ok) begin
                  ev[`TSL_EV_ACCEPT] = 1'b1;
                  errs_d = (errs_q == 4'h0) ? errs_q : 4'(errs_q - 4'h1);
                  if (link.value == `TSL_VAL_RESET) begin
                     st_d  = ST_NORMAL;
                     val_d = `TSL_VAL_RESET;
                  end else begin
                     st_d  = ST_LIMIT;
                     val_d = link.value;
                  end
               end else begin
                  ev[`TSL_EV_PW_ERR]   = !pw_ok;
                  ev[`TSL_EV_ROLL_ERR] = !roll_ok;
                  errs_d = (errs_q == 4'hF) ? errs_q : 4'(errs_q + 4'h1);
                  if (errs_d >= thr_q) begin
                     fault_d = 1'b1;
                     ev[`TSL_EV_FAULT] = 1'b1;
                  end
               end
            end
            REQ_INACTIVE: begin
               st_d  = ST_NORMAL;
               val_d = `TSL_VAL_RESET;
            end
            default: ;
         endcase
      end
      rp_d = (st_d == ST_LIMIT) || oth_s2_q;
   end

   // Link side registers
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q    <= ST_NORMAL;
         val_q   <= `TSL_VAL_RESET;
         prev_q  <= 2'h0;
         seen_q  <= 1'b0;
         errs_q  <= 4'h0;
         fault_q <= 1'b0;
         rp_q    <= 1'b0;
      end else begin
         st_q    <= st_d;
         val_q   <= val_d;
         prev_q  <= prev_d;
         seen_q  <= seen_d;
         errs_q  <= errs_d;
         fault_q <= fault_d;
         rp_q    <= rp_d;
      end
   end

   // Zero-wait slave, always OKAY
   assign hreadyout_o             = 1'b1;
   assign hresp_o                 = 1'b0;
   assign hrdata_o                = rdata_q;
   assign irq_o                   = irq_out_q;
   assign limit_active_o          = st_q[1];
   assign limit_value_o           = val_q;
   assign diagnostic_fault_code_o = fault_q;
   assign link.reduced_power      = rp_q;

endmodule // tsl_receiver

`default_nettype wire

/* tsl_regs.svh */
// Register offsets, field positions, reset values and timing counts
// for the speed limit command link. Definitions only.
`ifndef TSL_REGS_SVH
`define TSL_REGS_SVH

// Word offsets, shared by both ends
`define TSL_OFS_IDENT     8'h00
`define TSL_OFS_CTRL      8'h04
`define TSL_OFS_STATUS    8'h08
`define TSL_OFS_IRQ_STAT  8'h0C
`define TSL_OFS_IRQ_MASK  8'h10

// Reset values
`define TSL_IDENT_RST     32'h00000000
`define TSL_ERR_LIMIT_RST 4'h8
`define TSL_MASK_RST      4'h0

// Order register fields (sender)
`define TSL_ORDER_GO_BIT  8

// Value field code that means "back to normal"
`define TSL_VAL_RESET     8'hFF

// Receiver event bits
`define TSL_EV_ACCEPT     0
`define TSL_EV_PW_ERR     1
`define TSL_EV_ROLL_ERR   2
`define TSL_EV_FAULT      3

// Sender event bits
`define TSL_EV_RESET_DONE 0
`define TSL_EV_SENT       1

// Frame period of the sender
`define TSL_TX_PERIOD_MS  100
`define TSL_CLK_KHZ       250000
`define TSL_TX_PERIOD_CYC (`TSL_TX_PERIOD_MS * `TSL_CLK_KHZ)

`endif

/* tsl_sender.sv */
// Telematics side: turns software orders into periodic command frames.
// Assumes an AHB-Lite master on ref_clk_i and the receiver on the link.
`timescale 1ns/100ps
`default_nettype none

`include "tsl_regs.svh"

module tsl_sender
   import tsl_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = `TSL_TX_PERIOD_CYC
)(
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic             irq_o,
   tsl_if.snd               link
);

   logic        a_wr_q, a_wr_d;
   logic [7:0]  a_addr_q, a_addr_d;
   logic [31:0] ident_q, ident_d;
   logic [7:0]  ord_q, ord_d;
   logic [1:0]  mask_q, mask_d;
   logic [1:0]  irq_q, irq_d, irq_clr, ev;
   logic [31:0] rdata_q, rdata_d;
   logic        irq_out_q, irq_out_d;
   logic        acc, order, tick;
   logic [31:0] tick_q, tick_d;
   snd_state_e  st_q, st_d;
   logic        sent_q, sent_d;
   logic        frm_q, frm_d;
   req_code_e   req_q, req_d;
   logic [1:0]  roll_q, roll_d, roll_nx;
   logic [31:0] pw_q, pw_d, pw_nx;
   logic [7:0]  val_q, val_d;

   assign roll_nx = 2'(roll_q + 2'h1);

   // Password for the next active frame
   tsl_password u_pw (
      .chars_i    (ident_q),
      .roll_i     (roll_nx),
      .password_o (pw_nx)
   );

   // Registers, orders and frame generation
   always_comb begin
      acc      = hsel_i && htrans_i[1] && hready_i;
      a_wr_d   = acc && hwrite_i;
      a_addr_d = acc ? haddr_i[7:0] : a_addr_q;
      ident_d  = ident_q;
      ord_d    = ord_q;
      mask_d   = mask_q;
      irq_clr  = 2'h0;
      rdata_d  = 32'h00000000;
      order    = a_wr_q && (a_addr_q == `TSL_OFS_CTRL) && hwdata_i[`TSL_ORDER_GO_BIT];
      if (a_wr_q) begin
         case (a_addr_q)
            `TSL_OFS_IDENT:    ident_d = hwdata_i;
            `TSL_OFS_IRQ_MASK: mask_d = hwdata_i[1:0];
            default: ;
         endcase
      end
      if (order) begin
         ord_d = hwdata_i[7:0];
      end
      if (acc && !hwrite_i) begin
         case (haddr_i[7:0])
            `TSL_OFS_IDENT:    rdata_d = ident_d;
            `TSL_OFS_CTRL:     rdata_d = {24'h000000, ord_d};
            `TSL_OFS_STATUS:   rdata_d = {27'h0000000, link.reduced_power, st_q};
            `TSL_OFS_IRQ_STAT: begin
               rdata_d = {30'h00000000, irq_q};
               irq_clr = irq_q;
            end
            `TSL_OFS_IRQ_MASK: rdata_d = {30'h00000000, mask_d};
            default:           rdata_d = 32'h00000000;
         endcase
      end
      // Frame period divider
      tick   = (tick_q == 32'(PERIOD_CYC - 1));
      tick_d = tick ? 32'h00000000 : 32'(tick_q + 32'h1);
      st_d   = st_q;
      sent_d = sent_q;
      ev     = 2'h0;
      case (st_q)
         S_RESET: begin
            if (tick && sent_q && !link.reduced_power) begin
               st_d = S_INACT;
               ev[`TSL_EV_RESET_DONE] = 1'b1;
            end
         end
         S_IDLE, S_LIMIT, S_INACT: ;
         default: st_d = S_IDLE;
      endcase
      // A new order overrides whatever is being repeated
      if (order) begin
         st_d   = (hwdata_i[7:0] == `TSL_VAL_RESET) ? S_RESET : S_LIMIT;
         sent_d = 1'b0;
      end else if (tick && st_q == S_RESET) begin
         sent_d = 1'b1;
      end
      frm_d  = tick;
      req_d  = req_q;
      roll_d = roll_q;
      pw_d   = pw_q;
      val_d  = val_q;
      if (tick) begin
         ev[`TSL_EV_SENT] = 1'b1;
         val_d = `TSL_VAL_RESET;
         pw_d  = 32'h00000000;
         case (st_q)
            S_LIMIT, S_RESET: begin
               req_d  = REQ_ACTIVE;
               roll_d = roll_nx;
               pw_d   = pw_nx;
               val_d  = (st_q == S_LIMIT) ? ord_q : `TSL_VAL_RESET;
            end
            S_INACT: req_d = REQ_INACTIVE;
            default: req_d = REQ_NO_ACTION;
         endcase
      end
      irq_d     = (irq_q & ~irq_clr) | ev;
      irq_out_d = |(irq_d & mask_d);
   end

   // Registers only
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         a_wr_q    <= 1'b0;
         a_addr_q  <= 8'h00;
         ident_q   <= `TSL_IDENT_RST;
         ord_q     <= `TSL_VAL_RESET;
         mask_q    <= 2'h0;
         irq_q     <= 2'h0;
         rdata_q   <= 32'h00000000;
         irq_out_q <= 1'b0;
         tick_q    <= 32'h00000000;
         st_q      <= S_IDLE;
         sent_q    <= 1'b0;
         frm_q     <= 1'b0;
         req_q     <= REQ_NO_ACTION;
         roll_q    <= 2'h0;
         pw_q      <= 32'h00000000;
         val_q     <= `TSL_VAL_RESET;
      end else begin
         a_wr_q    <= a_wr_d;
         a_addr_q  <= a_addr_d;
         ident_q   <= ident_d;
         ord_q     <= ord_d;
         mask_q    <= mask_d;
         irq_q     <= irq_d;
         rdata_q   <= rdata_d;
         irq_out_q <= irq_out_d;
         tick_q    <= tick_d;
         st_q      <= st_d;
         sent_q    <= sent_d;
         frm_q     <= frm_d;
         req_q     <= req_d;
         roll_q    <= roll_d;
         pw_q      <= pw_d;
         val_q     <= val_d;
      end
   end

   assign hreadyout_o   = 1'b1;
   assign hresp_o       = 1'b0;
   assign hrdata_o      = rdata_q;
   assign irq_o         = irq_out_q;
   assign link.frame    = frm_q;
   assign link.req      = req_q;
   assign link.roll     = roll_q;
   assign link.password = pw_q;
   assign link.value    = val_q;

endmodule // tsl_sender

`default_nettype wire
